//--- tb/tb.sv
// Self-checking bench for the dual timer unit.
`timescale 1ns/100ps
module tb;
    logic mclk, rstn, cyc, we, ack, oe, pin, irq, cap;
    logic [15:0] adr, tog, v, a, b, k;
    logic [3:0] sel;
    logic [31:0] wdat, rdat, dat_o;
    int num_errors = 0;
    int comparisons = 0;
    int seed = 26;
    int cycles = 0;
    tgt_timer_unit tgt_timer_unit_i (.MCLK(mclk), .RSTN(rstn), .WB_CYC_I(cyc), .WB_STB_I(cyc),
        .WB_WE_I(we), .WB_ADR_I(adr), .WB_SEL_I(sel), .WB_DAT_I(wdat), .WB_DAT_O(dat_o),
        .WB_ACK_O(ack), .CAPTURE_IN_PIN(cap), .TOGGLE_OUT_PIN(pin), .TOGGLE_OUT_OE(oe), .IRQ(irq));
    tgt_cap_src tgt_cap_src_i (.clk(mclk), .pin(pin), .oe(oe), .cap(cap), .toggles(tog));
    initial begin
        mclk = 1'b0;
        forever #50 mclk = ~mclk;
    end
    task automatic report_and_stop();
        if (num_errors == 0 && comparisons > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask : report_and_stop
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 5000) begin
            num_errors++;
            report_and_stop();
        end
    end
    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        comparisons++;
        if (seen !== exp) begin
            num_errors++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask : check
    function automatic logic [31:0] rng(input logic [15:0] x, input int lo, input int hi);
        return {31'h0, x >= lo && x <= hi};
    endfunction : rng
    task automatic wb(input logic w, input logic [15:0] ad, input logic [15:0] d);
        int n;
        n = 0;
        cyc <= 1'b1;
        we <= w;
        adr <= ad;
        wdat <= {16'h0000, d};
        do begin
            @(posedge mclk);
            n++;
        end while (ack !== 1'b1 && n < 20);
        check("ack", {31'h0, ack}, 32'h1);
        rdat = dat_o;
        cyc <= 1'b0;
        @(posedge mclk);
    endtask : wb
    initial begin
        int i;
        {rstn, cyc, we, adr, wdat} = '0;
        sel = 4'h3;
        repeat (6) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        wb(1'b0, tgt_pkg::TGT_ADR_CIC, 16'h0000);
        check("irq ctrl reset", rdat, 32'h0);
        wb(1'b1, 16'h0020, 16'hffff);
        wb(1'b0, 16'h0020, 16'h0000);
        check("unmapped", rdat, 32'h0);
        for (i = 0; i < 6; i++) begin
            v = 16'($random(seed));
            wb(1'b1, tgt_pkg::TGT_ADR_CAP_RELOAD, v);
            wb(1'b0, tgt_pkg::TGT_ADR_CAP_RELOAD, 16'h0000);
            check("capture reload", rdat, {16'h0000, v});
        end
        for (i = 0; i < 4; i++) begin
            v = {2'b01, 14'($random(seed))};
            wb(1'b1, tgt_pkg::TGT_ADR_AUX, v);
            wb(1'b1, tgt_pkg::TGT_ADR_CORE, v);
            // Both timers run for equal windows, started and stopped three cycles apart.
            wb(1'b1, tgt_pkg::TGT_ADR_AUXCON, 16'(8 + 16 * (i % 2) + i / 2));
            wb(1'b1, tgt_pkg::TGT_ADR_CORECON, 16'(8 + 16 * (i % 2) + i / 2));
            repeat (40) @(posedge mclk);
            wb(1'b1, tgt_pkg::TGT_ADR_AUXCON, 16'h0000);
            wb(1'b1, tgt_pkg::TGT_ADR_CORECON, 16'h0000);
            wb(1'b0, tgt_pkg::TGT_ADR_AUX, 16'h0000);
            k = (i % 2) ? v - rdat[15:0] : rdat[15:0] - v;
            check("aux steps", rng(k, 10 / (1 + i / 2) - 1, 11 / (1 + i / 2) + 1), 1);
            wb(1'b0, tgt_pkg::TGT_ADR_CORE, 16'h0000);
            k = (i % 2) ? v - rdat[15:0] : rdat[15:0] - v;
            check("core steps", rng(k, 10 / (1 + i / 2) - 1, 11 / (1 + i / 2) + 1), 1);
        end
        wb(1'b1, tgt_pkg::TGT_ADR_MASK, 16'h0003);
        wb(1'b1, tgt_pkg::TGT_ADR_CAP_RELOAD, 16'hfffe);
        wb(1'b1, tgt_pkg::TGT_ADR_CORE, 16'hfffe);
        wb(1'b1, tgt_pkg::TGT_ADR_AUX, 16'h0000);
        wb(1'b1, tgt_pkg::TGT_ADR_AUXCON, 16'h0028);
        a = tog;
        wb(1'b1, tgt_pkg::TGT_ADR_CORECON, 16'h0068);
        repeat (80) @(posedge mclk);
        b = tog;
        check("output enable", {31'h0, oe}, 32'h1);
        check("irq on wrap", {31'h0, irq}, 32'h1);
        wb(1'b1, tgt_pkg::TGT_ADR_CORECON, 16'h0000);
        check("toggles", rng(b - a, 9, 11), 32'h1);
        check("pin off", {31'h0, pin}, 32'h0);
        wb(1'b1, tgt_pkg::TGT_ADR_AUXCON, 16'h0000);
        wb(1'b0, tgt_pkg::TGT_ADR_AUX, 16'h0000);
        check("chained count", rng(rdat[15:0], 9, 13), 32'h1);
        wb(1'b1, tgt_pkg::TGT_ADR_STAT, 16'h0007);
        check("irq cleared", {31'h0, irq}, 32'h0);
        for (i = 0; i < 2; i++) begin
            wb(1'b1, tgt_pkg::TGT_ADR_AUX, 16'h0000);
            wb(1'b1, tgt_pkg::TGT_ADR_AUXCON, 16'h00c8 | (16'h0100 << i));
            repeat (40) @(posedge mclk);
            tgt_cap_src_i.drive(i == 0);
            check("capture irq", {31'h0, irq}, 32'h1);
            wb(1'b0, tgt_pkg::TGT_ADR_CAP_RELOAD, 16'h0000);
            check("captured", rng(rdat[15:0], 9, 13), 32'h1);
            wb(1'b0, tgt_pkg::TGT_ADR_AUX, 16'h0000);
            check("cleared", rng(rdat[15:0], 0, 4), 32'h1);
            wb(1'b0, tgt_pkg::TGT_ADR_CIC, 16'h0000);
            check("request flag", rdat, 32'h0080);
            wb(1'b1, tgt_pkg::TGT_ADR_CIC, 16'h0000);
            wb(1'b1, tgt_pkg::TGT_ADR_STAT, 16'h0001);
            wb(1'b0, tgt_pkg::TGT_ADR_CIC, 16'h0000);
            check("flag cleared", rdat, 32'h0);
        end
        report_and_stop();
    end
endmodule : tb

//--- tb/tgt_cap_src.sv
// Model of the capture signal source and of the toggle pin load.
`timescale 1ns/100ps
module tgt_cap_src (
    input wire logic clk, // Clock.
    input wire logic pin, // Toggle pin.
    input wire logic oe, // Toggle pin enable.
    output logic cap, // Capture signal.
    output logic [15:0] toggles // Pin changes seen.
);
    logic last_r;
    initial begin
        cap = 1'b0;
        toggles = 16'h0000;
        last_r = 1'b0;
    end
    always @(posedge clk) begin
        if (oe && pin !== last_r) begin
            toggles <= toggles + 16'h0001;
        end
        last_r <= pin;
    end
    // Each level is held for two count steps so the sampler cannot miss it.
    task automatic drive(input logic lvl);
        cap <= lvl;
        repeat (8) @(posedge clk);
    endtask : drive
endmodule : tgt_cap_src

//--- tb/tgt_timer_unit_asserts.sv
// Checker of bus and pin relations at the timer unit's ports.
`timescale 1ns/100ps
module tgt_timer_unit_asserts (
    input wire logic MCLK, // Clock.
    input wire logic RSTN, // Reset.
    input wire logic WB_CYC_I, // Cycle.
    input wire logic WB_STB_I, // Strobe.
    input wire logic WB_WE_I, // Write.
    input wire logic [15:0] WB_ADR_I, // Address.
    input wire logic [3:0] WB_SEL_I, // Lanes.
    input wire logic [31:0] WB_DAT_I, // Write data.
    input wire logic [31:0] WB_DAT_O, // Read data.
    input wire logic WB_ACK_O, // Ack.
    input wire logic CAPTURE_IN_PIN, // Capture in.
    input wire logic TOGGLE_OUT_PIN, // Toggle out.
    input wire logic TOGGLE_OUT_OE, // Toggle enable.
    input wire logic IRQ // Interrupt.
);
    default clocking @(posedge MCLK); endclocking
    default disable iff (!RSTN);
    AST_ACK_AFTER_REQ: assert property (WB_CYC_I && WB_STB_I && !WB_ACK_O |=> WB_ACK_O)
        else $error("ack missing after request");
    AST_ACK_ONE: assert property (WB_ACK_O |=> !WB_ACK_O)
        else $error("ack longer than one cycle");
    AST_ACK_CAUSE: assert property (WB_ACK_O |-> $past(WB_CYC_I && WB_STB_I))
        else $error("ack without request");
    AST_UPPER_ZERO: assert property (WB_ACK_O |-> WB_DAT_O[31:16] == 16'h0000)
        else $error("upper read half not zero");
    AST_UNMAPPED: assert property (WB_CYC_I && !WB_WE_I && WB_ADR_I == 16'h0020 && !WB_ACK_O
        |=> WB_DAT_O == 32'h0)
        else $error("unmapped read not zero");
    AST_PIN_OE: assert property (TOGGLE_OUT_PIN |-> TOGGLE_OUT_OE)
        else $error("toggle pin high while disabled");
    AST_RESET_OUTS: assert property (disable iff (1'b0)
        !RSTN |=> !WB_ACK_O && !IRQ && !TOGGLE_OUT_OE)
        else $error("outputs not cleared by reset");
    // A wrap needs a full count step, so the pin cannot flip again for three cycles.
    AST_PIN_STEP: assert property ($changed(TOGGLE_OUT_PIN) && !WB_CYC_I && !$past(WB_CYC_I, 2)
        |=> (!$changed(TOGGLE_OUT_PIN) || WB_CYC_I || $past(WB_CYC_I, 2))[*3])
        else $error("toggle pin flipped faster than one step");
endmodule : tgt_timer_unit_asserts
bind tgt_timer_unit tgt_timer_unit_asserts tgt_timer_unit_asserts_i (.MCLK(MCLK), .RSTN(RSTN),
    .WB_CYC_I(WB_CYC_I), .WB_STB_I(WB_STB_I), .WB_WE_I(WB_WE_I), .WB_ADR_I(WB_ADR_I),
    .WB_SEL_I(WB_SEL_I), .WB_DAT_I(WB_DAT_I), .WB_DAT_O(WB_DAT_O), .WB_ACK_O(WB_ACK_O),
    .CAPTURE_IN_PIN(CAPTURE_IN_PIN), .TOGGLE_OUT_PIN(TOGGLE_OUT_PIN),
    .TOGGLE_OUT_OE(TOGGLE_OUT_OE), .IRQ(IRQ));

//--- verilog/tgt_counter.sv
// Sixteen-bit up/down counter with load and wrap detection.
`timescale 1ns/100ps
module tgt_counter (
    input wire logic clk, // Clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic inc, // Count step.
    input wire logic down, // Count down when high.
    input wire logic ld, // Load value.
    input wire logic [15:0] ld_val, // Value to load.
    output logic [15:0] cnt, // Count value.
    output logic wrap // Overflow or underflow on this step.
);
    assign wrap = inc && (down ? (cnt == 16'h0000) : (cnt == 16'hffff));

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cnt <= 16'h0000;
        end else if (ld) begin
            cnt <= ld_val;
        end else if (inc) begin
            cnt <= down ? cnt - 16'h0001 : cnt + 16'h0001;
        end
    end
endmodule : tgt_counter

//--- verilog/tgt_pkg.sv
// Package with register map, field positions, reset values and timing counts for the timer unit.
package tgt_pkg;
    // Half clock period in ns and the finest count step of eight half periods.
    localparam int TGT_CLK_NS = 100;
    localparam int TGT_HALF_CLOCK_NS = TGT_CLK_NS / 2;
    localparam int TGT_STEP_HALF_CLOCKS = 8;
    localparam int TGT_STEP_NS = TGT_STEP_HALF_CLOCKS * TGT_HALF_CLOCK_NS;
    localparam int TGT_STEP_CYC_I = (TGT_STEP_NS + TGT_CLK_NS - 1) / TGT_CLK_NS;
    localparam logic [7:0] TGT_STEP_CYC = 8'(TGT_STEP_CYC_I);
    // Word byte addresses on the bus.
    localparam logic [15:0] TGT_ADR_CIC = 16'hff6a;
    localparam logic [15:0] TGT_ADR_AUX = 16'h0000;
    localparam logic [15:0] TGT_ADR_CORE = 16'h0004;
    localparam logic [15:0] TGT_ADR_CAP_RELOAD = 16'h0008;
    localparam logic [15:0] TGT_ADR_AUXCON = 16'h000c;
    localparam logic [15:0] TGT_ADR_CORECON = 16'h0010;
    localparam logic [15:0] TGT_ADR_STAT = 16'h0014;
    localparam logic [15:0] TGT_ADR_MASK = 16'h0018;
    // Control register fields.
    localparam int TGT_F_PRE_LO = 0;
    localparam int TGT_F_PRE_HI = 2;
    localparam int TGT_F_RUN = 3;
    localparam int TGT_F_DOWN = 4;
    localparam int TGT_F_CONCAT = 5;
    localparam int TGT_F_CAPEN = 6;
    localparam int TGT_F_CLR = 7;
    localparam int TGT_F_EDGE_LO = 8;
    localparam int TGT_F_EDGE_HI = 9;
    localparam int TGT_F_RELOAD = 5;
    localparam int TGT_F_OUTEN = 6;
    localparam int TGT_F_LATCH = 7;
    // Interrupt control request flag and status bits.
    localparam int TGT_F_IR = 7;
    localparam int TGT_S_CAP = 0;
    localparam int TGT_S_CORE = 1;
    localparam int TGT_S_AUX = 2;
    localparam logic [15:0] TGT_RST16 = 16'h0000;
    localparam logic [2:0] TGT_STAT_W = 3'h0;
endpackage : tgt_pkg

//--- verilog/tgt_prescaler.sv
// Prescaler giving a count pulse every 2^sel steps of eight half clock periods.
`timescale 1ns/100ps
module tgt_prescaler (
    input wire logic clk, // Clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input wire logic [2:0] sel, // Prescale exponent.
    output logic tick // One-cycle count pulse.
);
    logic [7:0] step_r;
    logic [7:0] div_r;
    logic step;

    assign step = (step_r == tgt_pkg::TGT_STEP_CYC - 8'h01);

    always_ff @(posedge clk) begin
        if (!rst_n || step) begin
            step_r <= 8'h00;
        end else begin
            step_r <= step_r + 8'h01;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            div_r <= 8'h00;
        end else if (step) begin
            div_r <= div_r + 8'h01;
        end
    end

    // Tick fires when the low sel bits of the divider wrap.
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            tick <= 1'b0;
        end else begin
            tick <= step && ((div_r & ((8'h01 << sel) - 8'h01)) == ((8'h01 << sel) - 8'h01));
        end
    end
endmodule : tgt_prescaler

//--- verilog/tgt_timer_unit.sv
// Top of the dual timer unit with capture/reload register and Wishbone slave.
//
// The Wishbone register port was decided locally.
`timescale 1ns/100ps
// Summary of operation
// - Count step spans eight half clock periods
// - Two timers plus shared capture/reload register
// - Timers clocked by prescaled processor clock
// - Software selects count direction per timer
// - Toggle latch flips on core wrap
// - Aux timer may count toggle latch transitions
// - Toggle latch optionally drives output pin
// - Reload core timer on wrap when enabled
// - Capture pin edge copies aux timer
// - Optionally clear aux timer after capture
// - Interrupt control register at printed address
module tgt_timer_unit (
    input wire logic MCLK, // System clock.
    input wire logic RSTN, // Synchronous reset, active low.
    input wire logic WB_CYC_I, // Bus cycle.
    input wire logic WB_STB_I, // Bus strobe.
    input wire logic WB_WE_I, // Write enable.
    input wire logic [15:0] WB_ADR_I, // Byte address.
    input wire logic [3:0] WB_SEL_I, // Byte selects.
    input wire logic [31:0] WB_DAT_I, // Write data.
    output logic [31:0] WB_DAT_O, // Read data.
    output logic WB_ACK_O, // Acknowledge.
    input wire logic CAPTURE_IN_PIN, // External capture input.
    output logic TOGGLE_OUT_PIN, // Toggle latch output.
    output logic TOGGLE_OUT_OE, // Output enable of toggle pin.
    output logic IRQ // Level interrupt.
);
    logic [15:0] auxcon_r;
    logic [15:0] corecon_r;
    logic [15:0] capture_reload_reg_r;
    logic [15:0] capture_irq_ctrl_r;
    logic [2:0] stat_r;
    logic [2:0] mask_r;
    logic core_toggle_latch_r;
    logic latch_d_r;
    logic cap_q_r;
    logic aux_tick;
    logic core_tick;
    logic [15:0] aux_timer;
    logic [15:0] core_timer;
    logic aux_wrap;
    logic core_wrap;
    logic aux_inc;
    logic core_inc;
    logic cap_edge;
    logic capture;
    logic wr;
    logic rd;
    logic [15:0] wdat;
    logic [15:0] rdat;
    logic aux_ld;
    logic core_ld;
    logic [15:0] aux_ld_val;
    logic [15:0] core_ld_val;

    assign wr = WB_CYC_I && WB_STB_I && WB_WE_I && !WB_ACK_O;
    assign rd = WB_CYC_I && WB_STB_I && !WB_ACK_O;
    assign wdat = {WB_SEL_I[1] ? WB_DAT_I[15:8] : 8'h00, WB_SEL_I[0] ? WB_DAT_I[7:0] : 8'h00};

    // Each timer counts on its own prescaled clock; the aux timer does so only outside concatenated mode.
    tgt_prescaler u_aux_pre (
        .clk(MCLK),
        .rst_n(RSTN),
        .sel(auxcon_r[tgt_pkg::TGT_F_PRE_HI:tgt_pkg::TGT_F_PRE_LO]),
        .tick(aux_tick)
    );
    tgt_prescaler u_core_pre (
        .clk(MCLK),
        .rst_n(RSTN),
        .sel(corecon_r[tgt_pkg::TGT_F_PRE_HI:tgt_pkg::TGT_F_PRE_LO]),
        .tick(core_tick)
    );

    assign core_inc = corecon_r[tgt_pkg::TGT_F_RUN] && core_tick;
    // Concatenated mode counts every toggle latch transition instead of the prescaler.
    assign aux_inc = auxcon_r[tgt_pkg::TGT_F_RUN] && (auxcon_r[tgt_pkg::TGT_F_CONCAT] ?
        (core_toggle_latch_r != latch_d_r) : aux_tick);

    // Capture edge: bit 8 selects rising, bit 9 falling; the pin is assumed held per step.
    assign cap_edge = (auxcon_r[tgt_pkg::TGT_F_EDGE_LO] && !cap_q_r && CAPTURE_IN_PIN)
        || (auxcon_r[tgt_pkg::TGT_F_EDGE_HI] && cap_q_r && !CAPTURE_IN_PIN);
    assign capture = auxcon_r[tgt_pkg::TGT_F_CAPEN] && cap_edge;

    // A bus write to a timer beats hardware loads in the same cycle.
    always_comb begin
        aux_ld = 1'b0;
        aux_ld_val = tgt_pkg::TGT_RST16;
        core_ld = 1'b0;
        core_ld_val = tgt_pkg::TGT_RST16;
        if (wr && WB_ADR_I == tgt_pkg::TGT_ADR_AUX) begin
            aux_ld = 1'b1;
            aux_ld_val = wdat;
        end else if (capture && auxcon_r[tgt_pkg::TGT_F_CLR]) begin
            aux_ld = 1'b1;
            aux_ld_val = 16'h0000;
        end
        if (wr && WB_ADR_I == tgt_pkg::TGT_ADR_CORE) begin
            core_ld = 1'b1;
            core_ld_val = wdat;
        end else if (core_wrap && corecon_r[tgt_pkg::TGT_F_RELOAD]) begin
            core_ld = 1'b1;
            core_ld_val = capture_reload_reg_r;
        end
    end

    tgt_counter u_aux (
        .clk(MCLK),
        .rst_n(RSTN),
        .inc(aux_inc),
        .down(auxcon_r[tgt_pkg::TGT_F_DOWN]),
        .ld(aux_ld),
        .ld_val(aux_ld_val),
        .cnt(aux_timer),
        .wrap(aux_wrap)
    );
    tgt_counter u_core (
        .clk(MCLK),
        .rst_n(RSTN),
        .inc(core_inc),
        .down(corecon_r[tgt_pkg::TGT_F_DOWN]),
        .ld(core_ld),
        .ld_val(core_ld_val),
        .cnt(core_timer),
        .wrap(core_wrap)
    );

    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            core_toggle_latch_r <= 1'b0;
            latch_d_r <= 1'b0;
            cap_q_r <= 1'b0;
        end else begin
            latch_d_r <= core_toggle_latch_r;
            cap_q_r <= CAPTURE_IN_PIN;
            if (wr && WB_ADR_I == tgt_pkg::TGT_ADR_CORECON && WB_SEL_I[0]) begin
                core_toggle_latch_r <= WB_DAT_I[tgt_pkg::TGT_F_LATCH] ^ core_wrap;
            end else if (core_wrap) begin
                core_toggle_latch_r <= !core_toggle_latch_r;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            TOGGLE_OUT_PIN <= 1'b0;
            TOGGLE_OUT_OE <= 1'b0;
        end else begin
            TOGGLE_OUT_PIN <= corecon_r[tgt_pkg::TGT_F_OUTEN] && core_toggle_latch_r;
            TOGGLE_OUT_OE <= corecon_r[tgt_pkg::TGT_F_OUTEN];
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            auxcon_r <= tgt_pkg::TGT_RST16;
            corecon_r <= tgt_pkg::TGT_RST16;
        end else if (wr) begin
            if (WB_ADR_I == tgt_pkg::TGT_ADR_AUXCON) begin
                auxcon_r <= wdat;
            end
            if (WB_ADR_I == tgt_pkg::TGT_ADR_CORECON) begin
                corecon_r <= wdat;
            end
        end
    end

    // Capture wins over a software write in the same cycle.
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            capture_reload_reg_r <= tgt_pkg::TGT_RST16;
        end else if (capture) begin
            capture_reload_reg_r <= aux_timer;
        end else if (wr && WB_ADR_I == tgt_pkg::TGT_ADR_CAP_RELOAD) begin
            capture_reload_reg_r <= wdat;
        end
    end

    // Request flag: hardware set beats software clear.
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            capture_irq_ctrl_r <= tgt_pkg::TGT_RST16;
        end else begin
            if (wr && WB_ADR_I == tgt_pkg::TGT_ADR_CIC) begin
                capture_irq_ctrl_r <= wdat;
            end
            if (capture) begin
                capture_irq_ctrl_r[tgt_pkg::TGT_F_IR] <= 1'b1;
            end
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            stat_r <= tgt_pkg::TGT_STAT_W;
            mask_r <= tgt_pkg::TGT_STAT_W;
        end else begin
            if (wr && WB_ADR_I == tgt_pkg::TGT_ADR_MASK) begin
                mask_r <= wdat[2:0];
            end
            stat_r <= (stat_r & ~((wr && WB_ADR_I == tgt_pkg::TGT_ADR_STAT) ? wdat[2:0] : 3'h0))
                | {aux_wrap, core_wrap, capture};
        end
    end

    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            IRQ <= 1'b0;
        end else begin
            IRQ <= |(stat_r & mask_r);
        end
    end

    always_comb begin
        case (WB_ADR_I)
            tgt_pkg::TGT_ADR_AUX: rdat = aux_timer;
            tgt_pkg::TGT_ADR_CORE: rdat = core_timer;
            tgt_pkg::TGT_ADR_CAP_RELOAD: rdat = capture_reload_reg_r;
            tgt_pkg::TGT_ADR_AUXCON: rdat = auxcon_r;
            tgt_pkg::TGT_ADR_CORECON: rdat = {corecon_r[15:8], core_toggle_latch_r,
                corecon_r[6:0]};
            tgt_pkg::TGT_ADR_STAT: rdat = {13'h0000, stat_r};
            tgt_pkg::TGT_ADR_MASK: rdat = {13'h0000, mask_r};
            tgt_pkg::TGT_ADR_CIC: rdat = capture_irq_ctrl_r;
            default: rdat = 16'h0000;
        endcase
    end

    // One wait-free acknowledge per request; unmapped addresses read zero.
    always_ff @(posedge MCLK) begin
        if (!RSTN) begin
            WB_ACK_O <= 1'b0;
            WB_DAT_O <= 32'h00000000;
        end else begin
            WB_ACK_O <= rd;
            WB_DAT_O <= rd ? {16'h0000, rdat} : 32'h00000000;
        end
    end
endmodule : tgt_timer_unit
